// ---- cyclic_map_pkg.sv ----
package cyclic_map_pkg;

    // Register bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // Register indices
    localparam logic [3:0] CONFIG_OFS = 4'h0;
    localparam logic [3:0] STATION_OFS = 4'h1;
    localparam logic [3:0] STATE_OFS = 4'h2;
    localparam logic [3:0] FREQ_OFS = 4'h3;
    localparam logic [3:0] REPLY_OFS = 4'h4;

    // Config register field positions
    localparam int CFG_LAYOUT_LSB = 0;
    localparam int CFG_SIGN_BIT = 8;
    localparam int CFG_SPEED_BIT = 9;
    localparam int CFG_REMAP_BIT = 10;

    // Layout selection codes
    localparam logic [7:0] LAYOUT_V1A = 8'h00;
    localparam logic [7:0] LAYOUT_V1B = 8'h01;
    localparam logic [7:0] LAYOUT_X2 = 8'h0C;
    localparam logic [7:0] LAYOUT_X4 = 8'h0E;
    localparam logic [7:0] LAYOUT_X8A = 8'h12;
    localparam logic [7:0] LAYOUT_X8B = 8'h26;
    localparam logic [7:0] LAYOUT_P1 = 8'h64;
    localparam logic [7:0] LAYOUT_P2 = 8'h70;
    localparam logic [7:0] LAYOUT_P4 = 8'h72;
    localparam logic [7:0] LAYOUT_P8A = 8'h76;
    localparam logic [7:0] LAYOUT_P8B = 8'h8A;

    // Frequency limits and instruction codes
    localparam logic [15:0] FREQ_MAX_UNSIGNED = 16'hE678;
    localparam logic [7:0] set_freq_ram_code = 8'hED;
    localparam logic [7:0] set_freq_nv_code = 8'hEE;
    localparam logic [7:0] write_mode_error_code = 8'h01;
    localparam logic [7:0] REPLY_OK = 8'h00;

    // Command and status bit positions (word 0 / word 1)
    localparam int MONITOR_BIT = 12;
    localparam int RAM_WR_BIT = 13;
    localparam int NV_WR_BIT = 14;
    localparam int EXEC_BIT = 15;
    localparam int ERR_RST_BIT = 10;
    localparam int READY_BIT = 11;

    // Reset values
    localparam logic [7:0] LAYOUT_RESET = 8'h00;
    localparam logic [7:0] STATION_RESET = 8'h01;

    // Remote-register arrangement size
    typedef enum logic [1:0] {SIZE_X1, SIZE_X2, SIZE_X4, SIZE_X8} layout_size_t;

    // Drive state seen by the link
    typedef struct packed {
        logic run_fwd;
        logic run_rev;
        logic running;
        logic up_to_freq;
        logic overload;
        logic freq_detect;
        logic fault;
        logic in_position;
        logic pos_busy;
        logic home_done;
        logic home_fail;
        logic [6:0] assign_out;
    } drive_status_t;

    // Commands handed to the drive
    typedef struct packed {
        logic fwd;
        logic rev;
        logic jog;
        logic second_func;
        logic current_in;
        logic high_speed_select;
        logic middle_speed_select;
        logic low_speed_select;
        logic output_stop_input;
        logic [5:0] assign_in;
        logic error_reset;
        logic [15:0] freq_mag;
        logic freq_neg;
        logic is_speed;
        logic nv_store;
    } drive_cmd_t;

    // Whole module state
    typedef struct packed {
        logic [7:0] layout_pend;
        logic [7:0] layout_act;
        logic sign_sel;
        logic speed_sel;
        logic remap;
        logic [7:0] station;
        logic [15:0] freq_mag;
        logic freq_neg;
        logic [3:0] req_prev;
        logic err_prev;
        logic ram_done;
        logic nv_done;
        logic exec_done;
        logic [7:0] reply;
        logic [15:0] rdata;
        logic [15:0] stat0;
        logic [15:0] stat1;
        drive_cmd_t cmd;
    } state_t;

endpackage

// ---- cyclic_map_properties.sv ----
`timescale 1ns/100ps
`default_nettype none

module cyclic_map_properties (
    input wire logic clk,
    input wire logic rstn,
    input wire logic inverter_reset,
    input wire logic [15:0] cmd_word0,
    input wire logic [15:0] cmd_word1,
    input wire cyclic_map_pkg::drive_status_t drive_status,
    input wire logic [15:0] status_word0,
    input wire logic [15:0] status_word1,
    input wire cyclic_map_pkg::drive_cmd_t drive_cmd,
    input wire cyclic_map_pkg::layout_size_t layout_size,
    input wire logic plc_serves_registers
);
    cyclic_map_pkg::drive_status_t ds_q;
    logic [15:0] cw_q;
    logic up;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // Previous inputs, and a flag set one edge after reset
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ds_q <= '0;
            cw_q <= 16'h0000;
            up <= 1'b0;
        end
        else
        begin
            ds_q <= drive_status;
            cw_q <= cmd_word0;
            up <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Request handshake steps
    sequence ram_rise;
        $rose(cmd_word0[13]);
    endsequence
    sequence ram_fall;
        $fell(cmd_word0[13]);
    endsequence
    sequence err_pulse;
        drive_cmd.error_reset ##1 !drive_cmd.error_reset;
    endsequence

    chk_ram_answer: assert property (up ##0 ram_rise |=> status_word0[13])
        else $error("RAM write completion missing");
    chk_done_release: assert property (up ##0 ram_fall |=> !status_word0[13])
        else $error("RAM completion not released");
    chk_exec_answer: assert property (up && $rose(cmd_word0[15]) |=> status_word0[15])
        else $error("Execution completion missing");
    chk_monitor_echo: assert property (up |-> status_word0[12] == cw_q[12])
        else $error("Monitoring bit wrong");
    chk_run_bits: assert property (up |-> status_word0[7:0] == {ds_q.fault,
        ds_q.freq_detect, ds_q.assign_out[0], ds_q.overload, ds_q.up_to_freq,
        ds_q.running, ds_q.run_rev, ds_q.run_fwd})
        else $error("Status word zero low byte wrong");
    chk_pos_bits: assert property (up |-> status_word1[15:12] == {ds_q.home_fail,
        ds_q.home_done, ds_q.pos_busy, ds_q.in_position})
        else $error("Positioning status wrong");
    chk_fault_ready: assert property (up |-> status_word1[11:10] == {!ds_q.fault, ds_q.fault})
        else $error("Fault or ready flag wrong");
    chk_reserved_zero: assert property (status_word1[5:0] == 6'h00 && status_word1[9:8] == 2'h0)
        else $error("Reserved status bit set");
    chk_layout_hold: assert property (up && !$past(inverter_reset) |->
        $stable(layout_size) && $stable(plc_serves_registers))
        else $error("Layout changed without reset");
    chk_freq_cleared: assert property (up && $past(inverter_reset) |->
        drive_cmd.freq_mag == 16'h0000 && !drive_cmd.freq_neg)
        else $error("Frequency not cleared by reset");
    chk_err_pulse: assert property (up && $rose(cmd_word1[10]) |=> err_pulse)
        else $error("Error reset pulse wrong");
endmodule

bind inverter_cyclic_command_map cyclic_map_properties cyclic_map_properties_inst (
    .clk(clk), .rstn(rstn), .inverter_reset(inverter_reset), .cmd_word0(cmd_word0),
    .cmd_word1(cmd_word1),
    .drive_status(drive_status), .status_word0(status_word0), .status_word1(status_word1),
    .drive_cmd(drive_cmd), .layout_size(layout_size),
    .plc_serves_registers(plc_serves_registers)
);

`default_nettype wire

// ---- inverter_cyclic_command_map.sv ----
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module inverter_cyclic_command_map #(
    parameter int BASE_W = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [cyclic_map_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [cyclic_map_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [cyclic_map_pkg::DATA_W-1:0] reg_rdata,
    input wire logic inverter_reset,
    input wire logic [15:0] cmd_word0,
    input wire logic [15:0] cmd_word1,
    input wire logic [15:0] freq_command_word,
    input wire logic [15:0] instr_word,
    input wire logic [15:0] instr_data,
    input wire cyclic_map_pkg::drive_status_t drive_status,
    output logic [15:0] status_word0,
    output logic [15:0] status_word1,
    output logic [7:0] reply_code,
    output cyclic_map_pkg::drive_cmd_t drive_cmd,
    output cyclic_map_pkg::layout_size_t layout_size,
    output logic plc_serves_registers,
    output logic [BASE_W-1:0] image_base
);

    cyclic_map_pkg::state_t st_reg;
    cyclic_map_pkg::state_t st_next;

    ////////////////////////////////////////////////////////////////
    // Layout decode

    // Checks a selection value and gives its size and service
    function automatic logic [3:0] decode_layout(input logic [7:0] v);
        logic [3:0] r;
        r = 4'h0;
        case (v)
            cyclic_map_pkg::LAYOUT_V1A, cyclic_map_pkg::LAYOUT_V1B:
                r = {1'b1, 1'b0, cyclic_map_pkg::SIZE_X1};
            cyclic_map_pkg::LAYOUT_X2:
                r = {1'b1, 1'b0, cyclic_map_pkg::SIZE_X2};
            cyclic_map_pkg::LAYOUT_X4:
                r = {1'b1, 1'b0, cyclic_map_pkg::SIZE_X4};
            cyclic_map_pkg::LAYOUT_X8A, cyclic_map_pkg::LAYOUT_X8B:
                r = {1'b1, 1'b0, cyclic_map_pkg::SIZE_X8};
            cyclic_map_pkg::LAYOUT_P1:
                r = {1'b1, 1'b1, cyclic_map_pkg::SIZE_X1};
            cyclic_map_pkg::LAYOUT_P2:
                r = {1'b1, 1'b1, cyclic_map_pkg::SIZE_X2};
            cyclic_map_pkg::LAYOUT_P4:
                r = {1'b1, 1'b1, cyclic_map_pkg::SIZE_X4};
            cyclic_map_pkg::LAYOUT_P8A, cyclic_map_pkg::LAYOUT_P8B:
                r = {1'b1, 1'b1, cyclic_map_pkg::SIZE_X8};
            default:
                r = 4'h0;
        endcase
        return r;
    endfunction

    logic [3:0] act_dec;
    logic [3:0] wr_dec;
    logic [5:0] words;

    // Active arrangement and pending candidate
    always_comb
    begin
        act_dec = decode_layout(st_reg.layout_act);
        wr_dec = decode_layout(reg_wdata[7:0]);
        // Words per station run up to 32, so the vector is six bits wide
        words = 6'h04 << act_dec[1:0];
    end

    ////////////////////////////////////////////////////////////////
    // Command word interpretation

    logic ram_req;
    logic nv_req;
    logic exec_req;
    logic mon_req;
    logic ram_rise;
    logic nv_rise;
    logic exec_rise;
    logic both_enabled;
    logic [15:0] freq_mag_in;
    logic freq_neg_in;
    logic [15:0] abs_word;
    logic is_set_code;

    // Request edges and frequency word conversion
    always_comb
    begin
        mon_req = cmd_word0[cyclic_map_pkg::MONITOR_BIT];
        ram_req = cmd_word0[cyclic_map_pkg::RAM_WR_BIT];
        nv_req = cmd_word0[cyclic_map_pkg::NV_WR_BIT];
        exec_req = cmd_word0[cyclic_map_pkg::EXEC_BIT];
        ram_rise = ram_req & ~st_reg.req_prev[1];
        nv_rise = nv_req & ~st_reg.req_prev[2];
        exec_rise = exec_req & ~st_reg.req_prev[3];
        both_enabled = st_reg.layout_act != cyclic_map_pkg::LAYOUT_V1A;
        abs_word = 16'h0000 - freq_command_word;
        freq_neg_in = 1'b0;
        freq_mag_in = freq_command_word;
        if (st_reg.sign_sel)
        begin
            freq_neg_in = freq_command_word[15];
            if (freq_command_word[15])
            begin
                freq_mag_in = abs_word;
            end
        end
        else if (!st_reg.speed_sel
                 && freq_command_word > cyclic_map_pkg::FREQ_MAX_UNSIGNED)
        begin
            freq_mag_in = cyclic_map_pkg::FREQ_MAX_UNSIGNED;
        end
        is_set_code = instr_word[7:0] == cyclic_map_pkg::set_freq_ram_code
                   || instr_word[7:0] == cyclic_map_pkg::set_freq_nv_code;
    end

    ////////////////////////////////////////////////////////////////
    // Next state

    logic run_dir_swap;
    logic run_sel;
    logic fdet_sel;
    logic fault_sel;

    // Frequency writes, layout, handshakes and register bus
    always_comb
    begin
        st_next = st_reg;
        st_next.req_prev = {exec_req, nv_req, ram_req, mon_req};
        st_next.err_prev = cmd_word1[cyclic_map_pkg::ERR_RST_BIT];
        st_next.cmd.nv_store = 1'b0;

        // Frequency write requests
        if (ram_rise)
        begin
            st_next.freq_mag = freq_mag_in;
            st_next.freq_neg = freq_neg_in;
            st_next.reply = cyclic_map_pkg::REPLY_OK;
            st_next.ram_done = 1'b1;
        end
        if (nv_rise && !(ram_req && both_enabled))
        begin
            if (st_reg.sign_sel)
            begin
                st_next.reply = cyclic_map_pkg::write_mode_error_code;
            end
            else
            begin
                st_next.freq_mag = freq_mag_in;
                st_next.freq_neg = 1'b0;
                st_next.reply = cyclic_map_pkg::REPLY_OK;
                st_next.cmd.nv_store = 1'b1;
                st_next.nv_done = 1'b1;
            end
        end
        // Completion flags fall one cycle after their request drops
        if (!ram_req)
        begin
            st_next.ram_done = 1'b0;
        end
        if (!nv_req)
        begin
            st_next.nv_done = 1'b0;
        end

        // Instruction execution
        if (exec_rise)
        begin
            if (is_set_code)
            begin
                st_next.freq_mag = instr_data;
            end
            st_next.exec_done = 1'b1;
        end
        if (!exec_req)
        begin
            st_next.exec_done = 1'b0;
        end

        // Register writes
        if (reg_wr)
        begin
            case (reg_addr)
                cyclic_map_pkg::CONFIG_OFS:
                begin
                    if (wr_dec[3])
                    begin
                        st_next.layout_pend = reg_wdata[7:0];
                    end
                    st_next.sign_sel = reg_wdata[cyclic_map_pkg::CFG_SIGN_BIT];
                    st_next.speed_sel = reg_wdata[cyclic_map_pkg::CFG_SPEED_BIT];
                    st_next.remap = reg_wdata[cyclic_map_pkg::CFG_REMAP_BIT];
                end
                cyclic_map_pkg::STATION_OFS:
                begin
                    st_next.station = reg_wdata[7:0];
                end
                default:
                begin
                    st_next.station = st_next.station;
                end
            endcase
        end

        // Inverter reset applies layout and clears the frequency command and reply
        if (inverter_reset)
        begin
            st_next.layout_act = st_reg.layout_pend;
            st_next.freq_mag = 16'h0000;
            st_next.freq_neg = 1'b0;
            st_next.reply = cyclic_map_pkg::REPLY_OK;
        end

        // Register reads, answer in the next cycle
        st_next.rdata = 16'h0000;
        if (reg_rd)
        begin
            case (reg_addr)
                cyclic_map_pkg::CONFIG_OFS:
                    st_next.rdata = {5'h00, st_reg.remap, st_reg.speed_sel,
                                     st_reg.sign_sel, st_reg.layout_pend};
                cyclic_map_pkg::STATION_OFS:
                    st_next.rdata = {8'h00, st_reg.station};
                cyclic_map_pkg::STATE_OFS:
                    st_next.rdata = {4'h0, act_dec, st_reg.layout_act};
                cyclic_map_pkg::FREQ_OFS:
                    st_next.rdata = st_reg.freq_mag;
                cyclic_map_pkg::REPLY_OFS:
                    st_next.rdata = {7'h00, st_reg.freq_neg, st_reg.reply};
                default:
                    st_next.rdata = 16'h0000;
            endcase
        end

        // Drive commands from the bit image
        run_dir_swap = st_reg.sign_sel & st_reg.freq_neg;
        st_next.cmd.fwd = run_dir_swap ? cmd_word0[1] : cmd_word0[0];
        st_next.cmd.rev = run_dir_swap ? cmd_word0[0] : cmd_word0[1];
        st_next.cmd.high_speed_select = cmd_word0[2];
        st_next.cmd.middle_speed_select = cmd_word0[3];
        st_next.cmd.low_speed_select = cmd_word0[4];
        st_next.cmd.jog = cmd_word0[5];
        st_next.cmd.second_func = cmd_word0[6];
        st_next.cmd.current_in = cmd_word0[7];
        st_next.cmd.output_stop_input = cmd_word0[9];
        st_next.cmd.assign_in = {cmd_word1[13:11], cmd_word0[11:10],
                                 cmd_word0[8]};
        st_next.cmd.error_reset = cmd_word1[cyclic_map_pkg::ERR_RST_BIT]
                                & ~st_reg.err_prev;
        st_next.cmd.freq_mag = st_next.freq_mag;
        st_next.cmd.freq_neg = st_next.freq_neg;
        st_next.cmd.is_speed = st_reg.speed_sel;

        // Status image, defaults or assigned outputs
        run_sel = st_reg.remap ? drive_status.assign_out[0]
                               : drive_status.running;
        fdet_sel = st_reg.remap ? drive_status.assign_out[1]
                                : drive_status.freq_detect;
        fault_sel = st_reg.remap ? drive_status.assign_out[2]
                                 : drive_status.fault;
        st_next.stat0 = {st_next.exec_done, st_next.nv_done,
                         st_next.ram_done, mon_req,
                         drive_status.assign_out[6:3],
                         fault_sel, fdet_sel,
                         drive_status.assign_out[0],
                         drive_status.overload, drive_status.up_to_freq,
                         run_sel, drive_status.run_rev,
                         drive_status.run_fwd};
        // Second status word: positioning, ready, fault, assigned outputs
        st_next.stat1 = {drive_status.home_fail, drive_status.home_done,
                         drive_status.pos_busy,
                         drive_status.in_position,
                         ~drive_status.fault, drive_status.fault,
                         2'b00,
                         drive_status.assign_out[2:1],
                         6'h00};
    end

    ////////////////////////////////////////////////////////////////
    // State register

    // Power-on clears layout, sign and frequency
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_reg <= '0;
            st_reg.layout_pend <= cyclic_map_pkg::LAYOUT_RESET;
            st_reg.layout_act <= cyclic_map_pkg::LAYOUT_RESET;
            st_reg.station <= cyclic_map_pkg::STATION_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs

    // Registered images and derived base offset
    always_comb
    begin
        reg_rdata = st_reg.rdata;
        status_word0 = st_reg.stat0;
        status_word1 = st_reg.stat1;
        reply_code = st_reg.reply;
        drive_cmd = st_reg.cmd;
        layout_size = cyclic_map_pkg::layout_size_t'(act_dec[1:0]);
        plc_serves_registers = act_dec[2];
        image_base = BASE_W'(st_reg.station * words);
    end

endmodule

`default_nettype wire

// ---- inverter_cyclic_command_map_bench.sv ----
`timescale 1ns/100ps
`default_nettype none

module inverter_cyclic_command_map_bench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic inverter_reset = 1'b0;
    cyclic_map_pkg::drive_status_t drive_status = '0;
    logic [15:0] reg_rdata, status_word0, status_word1, cmd_word0, cmd_word1;
    logic [15:0] freq_command_word, instr_word, instr_data, image_base, seen, rd;
    logic [7:0] reply_code;
    logic plc_serves_registers;
    cyclic_map_pkg::drive_cmd_t drive_cmd;
    cyclic_map_pkg::layout_size_t layout_size;
    int err_total = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [7:0] codes [11] = '{8'h00, 8'h01, 8'h0C, 8'h0E, 8'h12, 8'h26,
        8'h64, 8'h70, 8'h72, 8'h76, 8'h8A};
    logic [1:0] sizes [11] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h0, 2'h1, 2'h2, 2'h3, 2'h3};

    always #25 clk = ~clk;

    inverter_cyclic_command_map inverter_cyclic_command_map_inst (
        .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .inverter_reset(inverter_reset), .cmd_word0(cmd_word0), .cmd_word1(cmd_word1),
        .freq_command_word(freq_command_word), .instr_word(instr_word),
        .instr_data(instr_data), .drive_status(drive_status), .status_word0(status_word0),
        .status_word1(status_word1), .reply_code(reply_code), .drive_cmd(drive_cmd),
        .layout_size(layout_size), .plc_serves_registers(plc_serves_registers),
        .image_base(image_base));

    link_master_model link_master_model_inst (
        .clk(clk), .status_word0(status_word0), .cmd_word0(cmd_word0),
        .cmd_word1(cmd_word1), .freq_command_word(freq_command_word),
        .instr_word(instr_word), .instr_data(instr_data), .seen(seen));

    ////////////////////////////////////////////////////////////////
    // Compare, bus access and reset helpers
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask

    task automatic pulse_reset();
        @(posedge clk);
        inverter_reset <= 1'b1;
        @(posedge clk);
        inverter_reset <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic cfg(input logic sign, input logic speed, input logic [7:0] layout);
        reg_write(cyclic_map_pkg::CONFIG_OFS, {6'h00, speed, sign, layout});
        pulse_reset();
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        check(image_base, 16'h0004);
        reg_write(cyclic_map_pkg::STATION_OFS, 16'h0003);
        // Every layout code, applied only by the inverter reset
        for (int i = 0; i < 11; i++)
        begin
            reg_write(cyclic_map_pkg::CONFIG_OFS, {8'h00, codes[i]});
            check({14'h0, layout_size}, {14'h0, (i == 0) ? 2'h0 : sizes[i - 1]});
            pulse_reset();
            check({14'h0, layout_size}, {14'h0, sizes[i]});
            check({15'h0, plc_serves_registers}, {15'h0, i > 5});
            check(image_base, 16'(3 * (4 << sizes[i])));
            reg_read(cyclic_map_pkg::STATE_OFS, rd);
            check(rd, {4'h0, 1'b1, i > 5, sizes[i], codes[i]});
        end
        reg_write(cyclic_map_pkg::CONFIG_OFS, 16'h000D);
        pulse_reset();
        reg_read(cyclic_map_pkg::STATE_OFS, rd);
        check(rd, 16'h0F8A);
        // Unsigned clamp, speed range, signed direction
        cfg(1'b0, 1'b0, 8'h00);
        link_master_model_inst.request(16'h2000, 16'hEA60, 16'h0000, 16'h0000);
        check(drive_cmd.freq_mag, cyclic_map_pkg::FREQ_MAX_UNSIGNED);
        reg_read(cyclic_map_pkg::FREQ_OFS, rd);
        check(rd, cyclic_map_pkg::FREQ_MAX_UNSIGNED);
        cfg(1'b0, 1'b1, 8'h00);
        link_master_model_inst.request(16'h2000, 16'hFFFF, 16'h0000, 16'h0000);
        check(drive_cmd.freq_mag, 16'hFFFF);
        cfg(1'b1, 1'b0, 8'h0C);
        link_master_model_inst.request(16'h2000, 16'hFC18, 16'h0000, 16'h0000);
        check(drive_cmd.freq_mag, 16'h03E8);
        reg_read(cyclic_map_pkg::REPLY_OFS, rd);
        check(rd, 16'h0100);
        link_master_model_inst.set_levels(10'h001, 16'h0000);
        repeat (2) @(posedge clk);
        check({14'h0, drive_cmd.fwd, drive_cmd.rev}, 16'h0001);
        link_master_model_inst.request(16'h4000, 16'h0064, 16'h0000, 16'h0000);
        check({8'h00, reply_code}, {8'h00, cyclic_map_pkg::write_mode_error_code});
        check(seen, 16'h0000);
        check(drive_cmd.freq_mag, 16'h03E8);
        // Instruction writes keep the sign
        link_master_model_inst.request(16'h8000, 16'h0000,
            {8'h00, cyclic_map_pkg::set_freq_ram_code}, 16'h01F4);
        check({drive_cmd.freq_neg, drive_cmd.freq_mag[14:0]}, 16'h81F4);
        link_master_model_inst.request(16'h8000, 16'h0000,
            {8'h00, cyclic_map_pkg::set_freq_nv_code}, 16'h0200);
        check({drive_cmd.freq_neg, drive_cmd.freq_mag[14:0]}, 16'h8200);
        pulse_reset();
        check({drive_cmd.freq_neg, drive_cmd.freq_mag[14:0]}, 16'h0000);
        check({14'h0, drive_cmd.fwd, drive_cmd.rev}, 16'h0002);
        // Both writes raised with a nonzero layout
        cfg(1'b0, 1'b0, 8'h0C);
        link_master_model_inst.request(16'h6000, 16'h0020, 16'h0000, 16'h0000);
        check(seen, 16'h2000);
        check(drive_cmd.freq_mag, 16'h0020);
        // Status image, with and without fault
        drive_status <= 18'h3FFFF;
        repeat (3) @(posedge clk);
        check(status_word0 & 16'h0FFF, 16'h0FFF);
        check(status_word1, 16'hF4C0);
        drive_status <= 18'h3F7FF;
        repeat (3) @(posedge clk);
        check(status_word0 & 16'h0FFF, 16'h0F7F);
        check(status_word1, 16'hF8C0);
        // Command bits, with reserved second-word bits set
        link_master_model_inst.set_levels(10'h255, 16'h3CFF);
        repeat (3) @(posedge clk);
        check({7'h00, drive_cmd.fwd, drive_cmd.rev, drive_cmd.jog, drive_cmd.second_func,
            drive_cmd.current_in, drive_cmd.high_speed_select, drive_cmd.middle_speed_select,
            drive_cmd.low_speed_select, drive_cmd.output_stop_input}, 16'h012B);
        check({10'h000, drive_cmd.assign_in}, 16'h0038);
        // Unmapped read and read-only write
        reg_read(4'hF, rd);
        check(rd, 16'h0000);
        reg_write(cyclic_map_pkg::FREQ_OFS, 16'h1234);
        reg_read(cyclic_map_pkg::FREQ_OFS, rd);
        check(rd, 16'h0020);
        close_out();
    end
endmodule

`default_nettype wire

// ---- link_master_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module link_master_model (
    input wire logic clk,
    input wire logic [15:0] status_word0,
    output logic [15:0] cmd_word0 = 16'h0000,
    output logic [15:0] cmd_word1 = 16'h0000,
    output logic [15:0] freq_command_word = 16'h0000,
    output logic [15:0] instr_word = 16'h0000,
    output logic [15:0] instr_data = 16'h0000,
    output logic [15:0] seen = 16'h0000
);
    // Level command bits of both words
    task automatic set_levels(input logic [9:0] w0, input logic [15:0] w1);
        @(posedge clk);
        cmd_word0[9:0] <= w0;
        cmd_word1 <= w1;
    endtask

    // Raise requests, hold until answered or given up, then drop
    task automatic request(input logic [15:0] bits, input logic [15:0] freq,
            input logic [15:0] code, input logic [15:0] data);
        int n;
        n = 0;
        seen = 16'h0000;
        @(posedge clk);
        freq_command_word <= freq;
        instr_word <= code;
        instr_data <= data;
        cmd_word0 <= cmd_word0 | bits;
        do
        begin
            @(posedge clk);
            n++;
            seen = seen | (status_word0 & 16'hE000);
        end
        while ((status_word0 & bits) == 16'h0000 && n < 6);
        @(posedge clk);
        seen = seen | (status_word0 & 16'hE000);
        // Released frequency and data words no longer show the last value
        cmd_word0 <= cmd_word0 & ~bits;
        freq_command_word <= ~freq;
        instr_data <= ~data;
        repeat (2) @(posedge clk);
    endtask
endmodule

`default_nettype wire
